// ### verilog/fetx_pkg.sv
package fetx_pkg;

  // Clock and symbol timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SER_RATE_MBPS = 125;
  localparam int NIB_PERIOD_NS = 40;
  localparam int NIB_DIV       = NIB_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NIB_CNT_W     = 3;

  // Data and symbol widths
  localparam int NIB_W = 4;
  localparam int SYM_W = 5;

  // Control code groups
  localparam logic [SYM_W-1:0] SYM_IDLE = 5'h1f;
  localparam logic [SYM_W-1:0] SYM_J    = 5'h18;
  localparam logic [SYM_W-1:0] SYM_K    = 5'h11;
  localparam logic [SYM_W-1:0] SYM_T    = 5'h0d;
  localparam logic [SYM_W-1:0] SYM_R    = 5'h07;

  // Nibble to code group table, indexed by nibble value
  localparam logic [SYM_W-1:0] CODE_TABLE [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
  };

  // Scrambler shape: x^11 + x^9 + 1
  localparam int LFSR_W   = 11;
  localparam int LFSR_TAP = 9;
  localparam int ADDR_W   = 5;

  // Cycles after reset release before the address straps are taken
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Transmit encoder states
  typedef enum logic [1:0] {
    FETX_ST_IDLE,
    FETX_ST_K,
    FETX_ST_DATA,
    FETX_ST_R
  } fetx_state_t;

endpackage

// ### verilog/fetx_buf.sv
`timescale 1ns/1ps
module fetx_buf #(
  parameter int W     = 5,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_nrst,
  // Fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [CW-1:0] count;

  wire            push       = i_valid && o_ready;
  wire            pop        = o_valid && i_ready;
  wire [CW-1:0]   next_count = count + CW'(push) - CW'(pop);
  wire [PW-1:0]   wptr_inc   = (wptr == PW'(DEPTH - 1)) ? '0 : wptr + PW'(1);
  wire [PW-1:0]   rptr_inc   = (rptr == PW'(DEPTH - 1)) ? '0 : rptr + PW'(1);

  assign o_data = mem[rptr];

  // Storage
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wptr] <= i_data;
    end
  end

  // Pointers, occupancy and registered flags
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wptr    <= '0;
      rptr    <= '0;
      count   <= '0;
      o_valid <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      if (push) wptr <= wptr_inc;
      if (pop) rptr <= rptr_inc;
      count   <= next_count;
      o_valid <= (next_count != '0);
      o_ready <= (next_count != CW'(DEPTH));
    end
  end

endmodule

// ### verilog/fetx_scram.sv
`timescale 1ns/1ps
module fetx_scram (
  // Clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_nrst,
  // Seed load
  input  wire logic                        i_load,
  input  wire logic [fetx_pkg::ADDR_W-1:0] i_addr,
  // Key stream
  output logic                             o_key
);

  logic [fetx_pkg::LFSR_W-1:0] lfsr;

  // Seed is never all zero: a forced one sits between the inverted address and the address
  wire [fetx_pkg::LFSR_W-1:0] seed = {~i_addr, 1'b1, i_addr};
  wire feedback = lfsr[fetx_pkg::LFSR_W-1] ^ lfsr[fetx_pkg::LFSR_TAP-1];

  assign o_key = feedback;

  // One shift per serial bit
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      lfsr <= '1;
    end else if (i_load) begin
      lfsr <= seed;
    end else begin
      lfsr <= {lfsr[fetx_pkg::LFSR_W-2:0], feedback};
    end
  end

endmodule

// ### verilog/fetx_top.sv
`timescale 1ns/1ps
module fetx_top (
  // Clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_nrst,
  // Transmit nibbles from the MAC
  input  wire logic                        i_tx_valid,
  input  wire logic                        i_tx_en,
  input  wire logic [fetx_pkg::NIB_W-1:0]  i_txd,
  output logic                             o_tx_ready,
  // Pins sampled from outside
  input  wire logic [fetx_pkg::ADDR_W-1:0] i_phy_address_straps,
  input  wire logic                        i_scr_bypass,
  // Line transmit pair streams
  output logic                             o_line_transmit_pair_pos,
  output logic                             o_line_transmit_pair_neg,
  // Status
  output logic                             o_tx_active
);

  // Buffer word: transmit enable above the nibble
  localparam int BUF_W = fetx_pkg::NIB_W + 1;

  // Nibble rate divider
  logic [fetx_pkg::NIB_CNT_W-1:0] nib_cnt;
  wire nib_tick = (nib_cnt == fetx_pkg::NIB_CNT_W'(fetx_pkg::NIB_DIV - 1));

  // Divider counts out one nibble slot of five serial bits
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      nib_cnt <= '0;
    end else if (nib_tick) begin
      nib_cnt <= '0;
    end else begin
      nib_cnt <= nib_cnt + fetx_pkg::NIB_CNT_W'(1);
    end
  end

  // Pin synchronisers
  logic [fetx_pkg::ADDR_W-1:0] strap_s1;
  logic [fetx_pkg::ADDR_W-1:0] strap_s2;
  logic                        byp_s1;
  logic                        byp_s2;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      byp_s1   <= 1'b0;
      byp_s2   <= 1'b0;
    end else begin
      strap_s1 <= i_phy_address_straps;
      strap_s2 <= strap_s1;
      byp_s1   <= i_scr_bypass;
      byp_s2   <= byp_s1;
    end
  end

  // Strap capture: one seed load once the synchroniser holds settled values
  logic [1:0] strap_cnt;
  logic       seed_load;
  wire        strap_wait_done = (strap_cnt == fetx_pkg::STRAP_WAIT);

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_cnt <= '0;
      seed_load <= 1'b0;
    end else begin
      if (!strap_wait_done) strap_cnt <= strap_cnt + 2'h1;
      seed_load <= (strap_cnt == fetx_pkg::STRAP_WAIT - 2'h1);
    end
  end

  // Two-entry buffer between the MAC and the encoder
  logic             buf_valid;
  logic [BUF_W-1:0] buf_data;
  fetx_pkg::fetx_state_t state;
  fetx_pkg::fetx_state_t next_state;

  // The encoder takes a word each nibble slot, except while R goes out
  wire buf_pop = nib_tick && (state != fetx_pkg::FETX_ST_R);

  fetx_buf #(
    .W     (BUF_W),
    .DEPTH (2)
  ) u_buf (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_valid (i_tx_valid),
    .i_data  ({i_tx_en, i_txd}),
    .o_ready (o_tx_ready),
    .o_valid (buf_valid),
    .o_data  (buf_data),
    .i_ready (buf_pop)
  );

  // An empty buffer in a slot reads as enable low
  wire                        en_now  = buf_valid && buf_data[fetx_pkg::NIB_W];
  wire [fetx_pkg::NIB_W-1:0]  nib_now = buf_data[fetx_pkg::NIB_W-1:0];
  wire [fetx_pkg::SYM_W-1:0]  data_sym = fetx_pkg::CODE_TABLE[nib_now];

  // Code group and next state selection
  logic [fetx_pkg::SYM_W-1:0] next_sym;

  always_comb begin
    next_state = state;
    next_sym   = fetx_pkg::SYM_IDLE;
    case (state)
      fetx_pkg::FETX_ST_IDLE: begin
        if (en_now) begin
          next_sym   = fetx_pkg::SYM_J;
          next_state = fetx_pkg::FETX_ST_K;
        end else begin
          next_sym = fetx_pkg::SYM_IDLE;
        end
      end
      fetx_pkg::FETX_ST_K: begin
        next_sym   = fetx_pkg::SYM_K;
        next_state = fetx_pkg::FETX_ST_DATA;
      end
      fetx_pkg::FETX_ST_DATA: begin
        if (en_now) begin
          next_sym = data_sym;
        end else begin
          next_sym   = fetx_pkg::SYM_T;
          next_state = fetx_pkg::FETX_ST_R;
        end
      end
      fetx_pkg::FETX_ST_R: begin
        next_sym   = fetx_pkg::SYM_R;
        next_state = fetx_pkg::FETX_ST_IDLE;
      end
      default: begin
        next_sym   = fetx_pkg::SYM_IDLE;
        next_state = fetx_pkg::FETX_ST_IDLE;
      end
    endcase
  end

  // Encoder state and frame status, one step per nibble slot
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state       <= fetx_pkg::FETX_ST_IDLE;
      o_tx_active <= 1'b0;
    end else if (nib_tick) begin
      state       <= next_state;
      o_tx_active <= (next_state != fetx_pkg::FETX_ST_IDLE) || (next_sym != fetx_pkg::SYM_IDLE);
    end
  end

  // Serialiser: load a code group per slot, shift out MSB first
  logic [fetx_pkg::SYM_W-1:0] sreg;
  wire nrz_bit = sreg[fetx_pkg::SYM_W-1];

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sreg <= fetx_pkg::SYM_IDLE;
    end else if (nib_tick) begin
      sreg <= next_sym;
    end else begin
      sreg <= {sreg[fetx_pkg::SYM_W-2:0], 1'b0};
    end
  end

  // Scrambler key stream
  logic key_bit;

  fetx_scram u_scram (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_load (seed_load),
    .i_addr (strap_s2),
    .o_key  (key_bit)
  );

  wire scr_bit = byp_s2 ? nrz_bit : (nrz_bit ^ key_bit);

  // NRZI stage and transition detection
  logic nrzi;
  logic nrzi_d;
  wire  one_evt = nrzi ^ nrzi_d;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      nrzi   <= 1'b0;
      nrzi_d <= 1'b0;
    end else begin
      nrzi   <= nrzi ^ scr_bit;
      nrzi_d <= nrzi;
    end
  end

  // Three-level phase: zero, plus, zero, minus, advanced by each NRZI transition
  localparam logic [1:0] PH_PLUS  = 2'h1;
  localparam logic [1:0] PH_MINUS = 2'h3;
  logic [1:0] phase;
  wire  [1:0] next_phase = one_evt ? phase + 2'h1 : phase;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase                    <= 2'h0;
      o_line_transmit_pair_pos <= 1'b0;
      o_line_transmit_pair_neg <= 1'b0;
    end else begin
      phase                    <= next_phase;
      o_line_transmit_pair_pos <= (next_phase == PH_PLUS);
      o_line_transmit_pair_neg <= (next_phase == PH_MINUS);
    end
  end

endmodule

// ### test/fetx_sva.sv
`timescale 1ns/1ps
module fetx_sva (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Word port and status
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_tx_active,
  // Line streams
  input wire logic o_line_transmit_pair_pos,
  input wire logic o_line_transmit_pair_neg
);
  wire  lp = o_line_transmit_pair_pos;
  wire  ln = o_line_transmit_pair_neg;
  logic last_pos;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Remembers which side carried the last nonzero level
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      last_pos <= 1'b0;
    end else if (lp) begin
      last_pos <= 1'b1;
    end else if (ln) begin
      last_pos <= 1'b0;
    end
  end
  a_never_both: assert property (!(lp && ln))
    else $error("both line streams high");
  a_pos_order: assert property ($rose(lp) |-> !last_pos)
    else $error("plus level out of turn");
  a_neg_order: assert property ($rose(ln) |-> last_pos)
    else $error("minus level out of turn");
  a_pos_via_zero: assert property (lp |=> !ln)
    else $error("plus to minus without zero");
  a_neg_via_zero: assert property (ln |=> !lp)
    else $error("minus to plus without zero");
  a_ready_fall: assert property ($fell(o_tx_ready) |-> $past(i_tx_valid))
    else $error("ready fell without offers");
  a_ready_back: assert property (!o_tx_ready |-> ##[1:12] o_tx_ready)
    else $error("ready stuck low");
  a_first_ready: assert property ($rose(i_nrst) |=> o_tx_ready)
    else $error("ready late after reset");
  a_slot_steady: assert property ($changed(o_tx_active) |=> $stable(o_tx_active)[*4])
    else $error("active changed inside a slot");
  c_frame: cover property ($rose(o_tx_active));
  c_full: cover property ($fell(o_tx_ready));
  c_minus: cover property ($rose(ln));
endmodule

// ### test/fetx_mac_model.sv
`timescale 1ns/1ps
module fetx_mac_model (
  // Clock and buffer state
  input  wire logic                       i_mclk,
  input  wire logic                       i_ready,
  // Word offered to the encoder
  output logic                            o_valid,
  output logic                            o_en,
  output logic [fetx_pkg::NIB_W-1:0]      o_txd
);
  // Nothing offered at start
  initial begin
    o_valid = 1'b0;
    o_en = 1'b0;
    o_txd = 4'h0;
  end
  // Offers one word and holds it until ready is seen before the edge
  task automatic put(input logic en, input logic [3:0] d);
    @(negedge i_mclk);
    o_valid = 1'b1;
    o_en = en;
    o_txd = d;
    while (!i_ready) @(negedge i_mclk);
  endtask
  // Withdraws the word; the data lines no longer show the old nibble
  task automatic rest(input int n);
    @(negedge i_mclk);
    o_valid = 1'b0;
    o_txd = ~o_txd;
    repeat (n - 1) @(negedge i_mclk);
  endtask
  // Preamble pair, nibbles 0 to f, then the closing word
  task automatic frame(input int gap);
    put(1'b1, 4'h5);
    put(1'b1, 4'h5);
    for (int i = 0; i < 16; i++) begin
      put(1'b1, i[3:0]);
      if (gap > 0) rest(gap);
    end
    put(1'b0, 4'h0);
    rest(1);
  endtask
endmodule

// ### test/fetx_top_tb_top.sv
`timescale 1ns/1ps
module fetx_top_tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        byp = 1'b1;
  logic [4:0]  straps = 5'h05;
  logic        valid;
  logic        en;
  logic [3:0]  txd;
  logic        rdy;
  logic        pos;
  logic        neg;
  logic        pp = 1'b0;
  logic        pn = 1'b0;
  logic        went_low = 1'b0;
  logic        act;
  logic        went_act = 1'b0;
  logic [14:0] hist = 15'h0000;
  logic [4:0]  cur;
  logic [4:0]  grp [$];
  logic [10:0] k1;
  logic [10:0] k2;
  int          ncap = 0;
  int          bc = 0;
  int          n_errors = 0;
  int          n_compared = 0;
  fetx_top i_fetx_top (.i_mclk(clk), .i_nrst(nrst), .i_tx_valid(valid), .i_tx_en(en), .i_txd(txd),
    .o_tx_ready(rdy), .i_phy_address_straps(straps), .i_scr_bypass(byp),
    .o_line_transmit_pair_pos(pos), .o_line_transmit_pair_neg(neg), .o_tx_active(act));
  fetx_mac_model i_fetx_mac_model (.i_mclk(clk), .i_ready(rdy), .o_valid(valid), .o_en(en), .o_txd(txd));
  // Clock
  initial begin
    forever #4 clk = ~clk;
  end
  // Line level change means a one; collect groups after idle J K
  always @(negedge clk) begin
    hist = {hist[13:0], 1'({pos, neg} != {pp, pn})};
    pp = pos;
    pn = neg;
    if (!rdy) went_low = 1'b1;
    if (act) went_act = 1'b1;
    if (ncap > 0) begin
      cur = {cur[3:0], hist[0]};
      bc++;
      if (bc == 5) begin
        grp.push_back(cur);
        bc = 0;
        ncap--;
      end
    end else if (hist == 15'b11111_11000_10001) begin
      ncap = 20;
    end
  end
  task automatic check(input logic [4:0] seen, input logic [4:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset;
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  // Unscrambled frame: data groups, end pair, idle
  task automatic scen_frame(input int gap);
    logic [4:0] e;
    int         k;
    grp.delete();
    went_low = 1'b0;
    went_act = 1'b0;
    k = 0;
    i_fetx_mac_model.frame(gap);
    while (grp.size() < 20 && k < 400) begin
      @(posedge clk);
      k++;
    end
    for (int i = 0; i < 20; i++) begin
      e = (i < 16) ? fetx_pkg::CODE_TABLE[i] : (i == 16) ? 5'b01101 : (i == 17) ? 5'b00111 : 5'b11111;
      check((grp.size() > i) ? grp[i] : 5'h00, e, "code group");
    end
    check(5'(went_low), 5'h01, "ready dropped");
    // Status is read off the launching edge
    @(negedge clk);
    check(5'(went_act), 5'h01, "active in frame");
    check(5'(act), 5'h00, "active after idle");
  endtask
  // Scrambled idle follows x^11+x^9+1 and is not all ones
  task automatic scen_scramble(input logic [4:0] addr, output logic [10:0] key);
    logic z;
    z = 1'b0;
    @(negedge clk);
    straps = addr;
    byp = 1'b0;
    do_reset;
    repeat (40) @(posedge clk);
    repeat (60) begin
      @(posedge clk);
      check(5'(hist[0] ^ hist[9] ^ hist[11]), 5'h01, "scramble relation");
      z = z | !hist[0];
    end
    check(5'(z), 5'h01, "scrambled zero");
    key = hist[10:0];
  endtask
  // Main sequence
  initial begin
    do_reset;
    scen_frame(0);
    scen_frame(2);
    scen_scramble(5'h05, k1);
    scen_scramble(5'h1a, k2);
    check(5'(k1 != k2), 5'h01, "seed differs");
    report_and_stop;
  end
  // Watchdog
  initial begin
    #60000;
    n_errors++;
    report_and_stop;
  end
endmodule
bind fetx_top fetx_sva i_fetx_sva (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_tx_valid(i_tx_valid),
  .o_tx_ready(o_tx_ready), .o_tx_active(o_tx_active), .o_line_transmit_pair_pos(o_line_transmit_pair_pos),
  .o_line_transmit_pair_neg(o_line_transmit_pair_neg));
